// File: inc/hpirq_cfg.svh
`ifndef HPIRQ_CFG_SVH
`define HPIRQ_CFG_SVH

// ============================================================
// Widths of the register port, channel count and group count.
`define HPIRQ_ADDR_W 5
`define HPIRQ_DATA_W 8
`define HPIRQ_CHANS 8
`define HPIRQ_GROUPS 4

// ============================================================
// Register addresses, one status, mask and flag per group.
`define HPIRQ_A_CA_STAT 5'h04
`define HPIRQ_A_DS_STAT 5'h05
`define HPIRQ_A_CA_MASK 5'h06
`define HPIRQ_A_DS_MASK 5'h07
`define HPIRQ_A_CA_FLAG 5'h08
`define HPIRQ_A_DS_FLAG 5'h09
`define HPIRQ_A_AS_STAT 5'h13
`define HPIRQ_A_AS_MASK 5'h14
`define HPIRQ_A_AS_FLAG 5'h15
`define HPIRQ_A_LC_STAT 5'h16
`define HPIRQ_A_LC_MASK 5'h17
`define HPIRQ_A_LC_FLAG 5'h18

// ============================================================
// Reset values and read value of unmapped addresses.
`define HPIRQ_MASK_RST 8'h00
`define HPIRQ_FLAG_RST 8'h00
`define HPIRQ_UNMAPPED_RD 8'h00

// ============================================================
// Serial word layout: command byte then data byte, first bit first.
`define HPIRQ_SER_BYTE_LAST 3'h7
`define HPIRQ_SER_RW_BIT 0
`define HPIRQ_SER_ADDR_LSB 1
`define HPIRQ_SER_ADDR_MSB 5

`endif

// File: inc/hpirq_pkg.sv
`include "hpirq_cfg.svh"

package hpirq_pkg;

  // ============================================================
  // Per-channel bits of the four status groups.
  typedef struct packed {
    logic [7:0] loop_code;
    logic [7:0] alarm_signal;
    logic [7:0] driver_short;
    logic [7:0] carrier_absent;
  } hpirq_group_t;

  // Same bits seen as an indexed array, group 0 is carrier_absent.
  typedef logic [`HPIRQ_GROUPS-1:0][`HPIRQ_DATA_W-1:0] hpirq_grp_arr_t;

  // Parallel port pins as seen after synchronisation.
  typedef struct packed {
    logic cs_n;
    logic strobe_n;
    logic dir;
    logic addr_strobe;
    logic [`HPIRQ_ADDR_W-1:0] addr;
    logic [`HPIRQ_DATA_W-1:0] data;
  } hpirq_par_pins_t;

  // Strap code formed by the three select pins.
  typedef enum logic [2:0] {
    HPIRQ_MODE_SERIAL = 3'h0,
    HPIRQ_MODE_STRB_SEP = 3'h4,
    HPIRQ_MODE_RDWR_SEP = 3'h5,
    HPIRQ_MODE_STRB_MUX = 3'h6,
    HPIRQ_MODE_RDWR_MUX = 3'h7
  } hpirq_mode_t;

  typedef enum logic [1:0] {
    HPIRQ_SER_IDLE = 2'b00,
    HPIRQ_SER_CMD = 2'b01,
    HPIRQ_SER_DATA = 2'b10,
    HPIRQ_SER_HOLD = 2'b11
  } hpirq_ser_state_t;

  typedef enum logic [0:0] {
    HPIRQ_PAR_IDLE = 1'b0,
    HPIRQ_PAR_ACCESS = 1'b1
  } hpirq_par_state_t;

endpackage : hpirq_pkg

// File: src/hpirq_sync.sv
`timescale 1ns/100ps

// ============================================================
// Three-stage input synchroniser; a bit changes once stages two and three agree.
module hpirq_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous input and its clean copy.
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_dout;

  if (W < 1) begin : g_bad_width
    $error("hpirq_sync needs a width of at least one.");
  end

  // Each bit follows the input only where the last two stages agree.
  always_comb begin
    next_dout = (dout & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= RST;
      s2 <= RST;
      s3 <= RST;
      dout <= RST;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end

endmodule : hpirq_sync

// File: src/hpirq_port.sv
`timescale 1ns/100ps
`include "hpirq_cfg.svh"

// Function
// - Select pin low (mid-supply) picks serial access, high picks parallel access.
// - Bus-style pin low gives separate address/data, high gives multiplexed bus.
// - Host-style pin low gives data strobe plus direction, high gives read/write strobes.
// - Code 100: chip select, acknowledge, strobe, direction, separate 5-bit address.
// - Code 101: chip select, ready, write and read strobes, separate 5-bit address.
// - Code 111: chip select, ready, read/write strobes, multiplexed address/data bus.
// - A serial access is sixteen bits: command byte first, then data byte.
// - Command byte holds direction flag and five address bits; two bits ignored.
// - Direction flag one shifts the addressed register out during the data byte.
// - Direction flag zero stores the data byte into the addressed mask register; other addresses ignore the write.
// - Interrupt sources are four per-channel status groups.
// - Each status bit shows live whether its condition is present.
// - All groups report through one latched active-low interrupt request.
// - A channel flag is enabled only while its mask bit is one.
// - Any change of an enabled status bit sets its flag and asserts request.
// - The request only pulls low or releases, for a shared pulled-up line.
// - Masks reset to zero; a zero mask blocks flag setting.
// - Reading a group's status register clears that group's flags.
// - Status bits fall back by themselves when the condition ends.
// - The request releases once no flag remains set.
// - Every access mode selects registers with exactly five address bits.
module hpirq_port (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Mode straps.
  input wire logic serial_parallel_select_pin,
  input wire logic bus_muxing_select_pin,
  input wire logic host_style_select_pin,
  // Serial host port.
  input wire logic serial_clk,
  input wire logic serial_cs_n,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic serial_out_oe,
  // Parallel host port.
  input wire logic par_cs_n,
  input wire logic par_strobe_n,
  input wire logic par_dir,
  input wire logic par_addr_strobe,
  input wire logic [`HPIRQ_ADDR_W-1:0] par_addr,
  input wire logic [`HPIRQ_DATA_W-1:0] par_data_in,
  output logic [`HPIRQ_DATA_W-1:0] par_data_out,
  output logic par_data_oe,
  output logic par_ack_n,
  output logic par_rdy,
  // Live condition bits from the detectors.
  input wire hpirq_pkg::hpirq_group_t status_in,
  // Open-drain interrupt request.
  output logic irq_n_out,
  output logic irq_n_oe
);

  import hpirq_pkg::*;

  // ============================================================
  // Register map tables, indexed by group.
  localparam logic [`HPIRQ_ADDR_W-1:0] STAT_A [`HPIRQ_GROUPS] = '{
    `HPIRQ_A_CA_STAT, `HPIRQ_A_DS_STAT, `HPIRQ_A_AS_STAT, `HPIRQ_A_LC_STAT};
  localparam logic [`HPIRQ_ADDR_W-1:0] MASK_A [`HPIRQ_GROUPS] = '{
    `HPIRQ_A_CA_MASK, `HPIRQ_A_DS_MASK, `HPIRQ_A_AS_MASK, `HPIRQ_A_LC_MASK};
  localparam logic [`HPIRQ_ADDR_W-1:0] FLAG_A [`HPIRQ_GROUPS] = '{
    `HPIRQ_A_CA_FLAG, `HPIRQ_A_DS_FLAG, `HPIRQ_A_AS_FLAG, `HPIRQ_A_LC_FLAG};

  // Read decode shared by the serial and parallel engines.
  function automatic logic [`HPIRQ_DATA_W-1:0] rd_word(
    input logic [`HPIRQ_ADDR_W-1:0] a,
    input hpirq_grp_arr_t st,
    input hpirq_grp_arr_t mk,
    input hpirq_grp_arr_t fl);
    logic [`HPIRQ_DATA_W-1:0] r;
    r = `HPIRQ_UNMAPPED_RD;
    for (int g = 0; g < `HPIRQ_GROUPS; g++) begin
      if (a == STAT_A[g]) begin
        r = st[g];
      end
      if (a == MASK_A[g]) begin
        r = mk[g];
      end
      if (a == FLAG_A[g]) begin
        r = fl[g];
      end
    end
    return r;
  endfunction : rd_word

  // ============================================================
  // Input synchronisers.
  logic [2:0] strap;
  logic [2:0] ser_pins;
  hpirq_par_pins_t pp;
  hpirq_mode_t mode;

  hpirq_sync #(.W(3), .RST(3'h0)) u_sync_strap (
    .clk(clk),
    .rst_n(rst_n),
    .din({serial_parallel_select_pin, bus_muxing_select_pin, host_style_select_pin}),
    .dout(strap)
  );

  hpirq_sync #(.W(3), .RST(3'h7)) u_sync_ser (
    .clk(clk),
    .rst_n(rst_n),
    .din({serial_clk, serial_cs_n, serial_in_line}),
    .dout(ser_pins)
  );

  hpirq_sync #(.W($bits(hpirq_par_pins_t)), .RST({4'hf, 13'h0000})) u_sync_par (
    .clk(clk),
    .rst_n(rst_n),
    .din({par_cs_n, par_strobe_n, par_dir, par_addr_strobe, par_addr, par_data_in}),
    .dout(pp)
  );

  // Only the top pin decides serial; the two low pins matter only for parallel.
  assign mode = strap[2] ? hpirq_mode_t'(strap) : HPIRQ_MODE_SERIAL;

  // ============================================================
  // Shared access strobes from either engine.
  logic ser_wr;
  logic ser_rd_done;
  logic [`HPIRQ_ADDR_W-1:0] ser_acc_addr;
  logic [`HPIRQ_DATA_W-1:0] ser_acc_data;
  logic par_wr;
  logic par_rd_done;
  logic [`HPIRQ_ADDR_W-1:0] par_acc_addr;
  logic [`HPIRQ_DATA_W-1:0] par_acc_data;
  logic acc_wr;
  logic acc_rd_done;
  logic [`HPIRQ_ADDR_W-1:0] acc_addr;
  logic [`HPIRQ_DATA_W-1:0] acc_data;

  // Engine of the selected interface owns the register port.
  always_comb begin
    if (mode == HPIRQ_MODE_SERIAL) begin
      acc_wr = ser_wr;
      acc_rd_done = ser_rd_done;
      acc_addr = ser_acc_addr;
      acc_data = ser_acc_data;
    end else begin
      acc_wr = par_wr;
      acc_rd_done = par_rd_done;
      acc_addr = par_acc_addr;
      acc_data = par_acc_data;
    end
  end

  // ============================================================
  // Interrupt registers.
  hpirq_grp_arr_t stat;
  hpirq_grp_arr_t prev;
  hpirq_grp_arr_t mask;
  hpirq_grp_arr_t flag;
  hpirq_grp_arr_t next_mask;
  hpirq_grp_arr_t next_flag;
  logic irq_pend;
  logic next_irq_pend;

  // Detector bits are shown as they are, so they fall back on their own.
  assign stat = status_in;

  // Masks take writes, flags latch enabled edges and clear when status is read.
  always_comb begin
    for (int g = 0; g < `HPIRQ_GROUPS; g++) begin
      next_mask[g] = mask[g];
      if (acc_wr && acc_addr == MASK_A[g]) begin
        next_mask[g] = acc_data;
      end
      next_flag[g] = flag[g];
      if (acc_rd_done && acc_addr == STAT_A[g]) begin
        next_flag[g] = `HPIRQ_FLAG_RST;
      end
      // A new edge in the clearing cycle still sets its flag.
      next_flag[g] = next_flag[g] | (mask[g] & (stat[g] ^ prev[g]));
    end
    next_irq_pend = |next_flag;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= '0;
      mask <= {`HPIRQ_GROUPS{`HPIRQ_MASK_RST}};
      flag <= {`HPIRQ_GROUPS{`HPIRQ_FLAG_RST}};
      irq_pend <= 1'b0;
    end else begin
      prev <= stat;
      mask <= next_mask;
      flag <= next_flag;
      irq_pend <= next_irq_pend;
    end
  end

  // The request line is never driven high, only pulled low or released.
  assign irq_n_out = 1'b0;
  assign irq_n_oe = irq_pend;

  // ============================================================
  // Serial engine.
  hpirq_ser_state_t ser_state;
  hpirq_ser_state_t next_ser_state;
  logic sclk_prev;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [`HPIRQ_DATA_W-1:0] in_sh;
  logic [`HPIRQ_DATA_W-1:0] next_in_sh;
  logic [`HPIRQ_DATA_W-1:0] out_sh;
  logic [`HPIRQ_DATA_W-1:0] next_out_sh;
  logic cmd_rd;
  logic next_cmd_rd;
  logic [`HPIRQ_ADDR_W-1:0] cmd_addr;
  logic [`HPIRQ_ADDR_W-1:0] next_cmd_addr;
  logic ser_oe;
  logic next_ser_oe;
  logic s_clk;
  logic s_cs_n;
  logic s_din;
  logic s_rise;
  logic s_fall;

  assign {s_clk, s_cs_n, s_din} = ser_pins;
  assign s_rise = s_clk & ~sclk_prev;
  assign s_fall = ~s_clk & sclk_prev;

  // Bits enter first-bit-first on rising clock; read data leaves on falling clock.
  always_comb begin
    next_ser_state = ser_state;
    next_bit_cnt = bit_cnt;
    next_in_sh = in_sh;
    next_out_sh = out_sh;
    next_cmd_rd = cmd_rd;
    next_cmd_addr = cmd_addr;
    next_ser_oe = ser_oe;
    ser_wr = 1'b0;
    ser_rd_done = 1'b0;
    ser_acc_addr = cmd_addr;
    ser_acc_data = {s_din, in_sh[`HPIRQ_DATA_W-1:1]};
    if (s_cs_n || mode != HPIRQ_MODE_SERIAL) begin
      next_ser_state = HPIRQ_SER_IDLE;
      next_ser_oe = 1'b0;
    end else begin
      case (ser_state)
        HPIRQ_SER_IDLE: begin
          next_ser_state = HPIRQ_SER_CMD;
          next_bit_cnt = 3'h0;
        end
        HPIRQ_SER_CMD: begin
          if (s_rise) begin
            next_in_sh = ser_acc_data;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `HPIRQ_SER_BYTE_LAST) begin
              // Bits six and seven of the command are dropped here.
              next_cmd_rd = ser_acc_data[`HPIRQ_SER_RW_BIT];
              next_cmd_addr = ser_acc_data[`HPIRQ_SER_ADDR_MSB:`HPIRQ_SER_ADDR_LSB];
              next_ser_state = HPIRQ_SER_DATA;
              next_bit_cnt = 3'h0;
              if (ser_acc_data[`HPIRQ_SER_RW_BIT]) begin
                next_out_sh = rd_word(next_cmd_addr, stat, mask, flag);
                next_ser_oe = 1'b1;
              end
            end
          end
        end
        HPIRQ_SER_DATA: begin
          if (s_rise) begin
            next_in_sh = ser_acc_data;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `HPIRQ_SER_BYTE_LAST) begin
              ser_wr = ~cmd_rd;
              ser_rd_done = cmd_rd;
              next_ser_state = HPIRQ_SER_HOLD;
            end
          end else if (s_fall && cmd_rd && bit_cnt != 3'h0) begin
            next_out_sh = {1'b0, out_sh[`HPIRQ_DATA_W-1:1]};
          end
        end
        HPIRQ_SER_HOLD: begin
          // Extra clocks are ignored until chip select is released.
          if (s_fall) begin
            next_ser_oe = 1'b0;
          end
        end
        default: begin
          next_ser_state = HPIRQ_SER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_state <= HPIRQ_SER_IDLE;
      sclk_prev <= 1'b1;
      bit_cnt <= 3'h0;
      in_sh <= 8'h00;
      out_sh <= 8'h00;
      cmd_rd <= 1'b0;
      cmd_addr <= 5'h00;
      ser_oe <= 1'b0;
    end else begin
      ser_state <= next_ser_state;
      sclk_prev <= s_clk;
      bit_cnt <= next_bit_cnt;
      in_sh <= next_in_sh;
      out_sh <= next_out_sh;
      cmd_rd <= next_cmd_rd;
      cmd_addr <= next_cmd_addr;
      ser_oe <= next_ser_oe;
    end
  end

  assign serial_out_line = out_sh[0];
  assign serial_out_oe = ser_oe;

  // ============================================================
  // Parallel engine.
  hpirq_par_state_t par_state;
  hpirq_par_state_t next_par_state;
  logic is_rdwr;
  logic is_mux;
  logic p_active;
  logic p_read;
  logic p_latch;
  logic acc_rd;
  logic next_acc_rd;
  logic [`HPIRQ_ADDR_W-1:0] mux_addr;
  logic [`HPIRQ_ADDR_W-1:0] next_mux_addr;
  logic [`HPIRQ_ADDR_W-1:0] p_addr;
  logic [`HPIRQ_ADDR_W-1:0] next_p_addr;
  logic [`HPIRQ_DATA_W-1:0] din_hold;
  logic [`HPIRQ_DATA_W-1:0] next_din_hold;
  logic [`HPIRQ_DATA_W-1:0] next_par_data_out;
  logic next_par_data_oe;

  assign is_rdwr = strap[0];
  assign is_mux = strap[1];

  // Strobe style uses strobe plus direction; read/write style uses two strobes.
  always_comb begin
    if (is_rdwr) begin
      p_active = ~pp.cs_n & (~pp.strobe_n | ~pp.dir);
      p_read = ~pp.dir;
      p_latch = pp.addr_strobe;
    end else begin
      p_active = ~pp.cs_n & ~pp.strobe_n;
      p_read = pp.dir;
      p_latch = ~pp.addr_strobe;
    end
  end

  // Access opens on strobe assertion and commits on its release.
  always_comb begin
    next_par_state = par_state;
    next_acc_rd = acc_rd;
    next_p_addr = p_addr;
    next_din_hold = din_hold;
    next_par_data_out = par_data_out;
    next_par_data_oe = par_data_oe;
    next_mux_addr = mux_addr;
    par_wr = 1'b0;
    par_rd_done = 1'b0;
    par_acc_addr = p_addr;
    par_acc_data = din_hold;
    if (is_mux && p_latch && par_state == HPIRQ_PAR_IDLE) begin
      next_mux_addr = pp.data[`HPIRQ_ADDR_W-1:0];
    end
    if (mode == HPIRQ_MODE_SERIAL) begin
      next_par_state = HPIRQ_PAR_IDLE;
      next_par_data_oe = 1'b0;
    end else begin
      case (par_state)
        HPIRQ_PAR_IDLE: begin
          if (p_active) begin
            next_par_state = HPIRQ_PAR_ACCESS;
            next_p_addr = is_mux ? mux_addr : pp.addr;
            next_acc_rd = p_read;
            next_din_hold = pp.data;
            if (p_read) begin
              next_par_data_out = rd_word(next_p_addr, stat, mask, flag);
              next_par_data_oe = 1'b1;
            end
          end
        end
        HPIRQ_PAR_ACCESS: begin
          if (p_active) begin
            next_din_hold = pp.data;
          end else begin
            next_par_state = HPIRQ_PAR_IDLE;
            next_par_data_oe = 1'b0;
            par_wr = ~acc_rd;
            par_rd_done = acc_rd;
          end
        end
        default: begin
          next_par_state = HPIRQ_PAR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      par_state <= HPIRQ_PAR_IDLE;
      acc_rd <= 1'b0;
      p_addr <= 5'h00;
      mux_addr <= 5'h00;
      din_hold <= 8'h00;
      par_data_out <= 8'h00;
      par_data_oe <= 1'b0;
    end else begin
      par_state <= next_par_state;
      acc_rd <= next_acc_rd;
      p_addr <= next_p_addr;
      mux_addr <= next_mux_addr;
      din_hold <= next_din_hold;
      par_data_out <= next_par_data_out;
      par_data_oe <= next_par_data_oe;
    end
  end

  // Acknowledge for strobe style, ready for read/write style, during the access.
  assign par_ack_n = ~(par_state == HPIRQ_PAR_ACCESS && !is_rdwr);
  assign par_rdy = (par_state == HPIRQ_PAR_ACCESS) && is_rdwr;

endmodule : hpirq_port

// File: bench/hpirq_port_checker.sv
`timescale 1ns/100ps
`include "hpirq_cfg.svh"

// ============================================================
// Port checker
module hpirq_port_checker
  import hpirq_pkg::*;
(
  // Clock, reset and straps.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_parallel_select_pin,
  input wire logic bus_muxing_select_pin,
  input wire logic host_style_select_pin,
  // Serial port.
  input wire logic serial_clk,
  input wire logic serial_cs_n,
  input wire logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic serial_out_oe,
  // Parallel port.
  input wire logic par_cs_n,
  input wire logic par_strobe_n,
  input wire logic par_dir,
  input wire logic par_addr_strobe,
  input wire logic [`HPIRQ_ADDR_W-1:0] par_addr,
  input wire logic [`HPIRQ_DATA_W-1:0] par_data_in,
  input wire logic [`HPIRQ_DATA_W-1:0] par_data_out,
  input wire logic par_data_oe,
  input wire logic par_ack_n,
  input wire logic par_rdy,
  // Status and interrupt.
  input wire hpirq_pkg::hpirq_group_t status_in,
  input wire logic irq_n_out,
  input wire logic irq_n_oe
);
  logic [3:0] since_chg;
  logic [3:0] next_since_chg;
  hpirq_group_t prev_status;

  // Cycles since the last status change, saturating.
  always_comb begin
    next_since_chg = (status_in != prev_status) ? 4'h0 :
                     ((since_chg == 4'hf) ? since_chg : since_chg + 4'h1);
  end

  // Registers the change counter and the previous status.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_chg <= 4'hf;
      prev_status <= '0;
    end else begin
      since_chg <= next_since_chg;
      prev_status <= status_in;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_cs_idle; serial_cs_n [*8]; endsequence
  sequence s_par_mode; serial_parallel_select_pin [*8]; endsequence
  sequence s_ser_mode; !serial_parallel_select_pin [*8]; endsequence

  chk_irq_only_pulls: assert property (irq_n_out == 1'b0)
    else $error("interrupt pin drives high");
  chk_irq_set_cause: assert property ($rose(irq_n_oe) |-> since_chg <= 4'h4)
    else $error("interrupt without status change");
  chk_irq_clear_read: assert property ($fell(irq_n_oe) |->
    $past(par_data_oe) || $past(par_data_oe, 2) || $past(serial_out_oe) || $past(serial_out_oe, 2))
    else $error("interrupt released without a read");
  chk_ser_oe_release: assert property (s_cs_idle |-> !serial_out_oe)
    else $error("serial output with select high");
  chk_par_off_serial: assert property (s_ser_mode |-> !par_data_oe && par_ack_n && !par_rdy)
    else $error("parallel port active in serial mode");
  chk_ser_off_par: assert property (s_par_mode |-> !serial_out_oe)
    else $error("serial port active in parallel mode");
  chk_ack_rdwr_style: assert property (host_style_select_pin [*8] |-> par_ack_n)
    else $error("acknowledge in read/write strobe style");
  chk_rdy_strb_style: assert property (!host_style_select_pin [*8] |-> !par_rdy)
    else $error("ready in data strobe style");
  chk_drive_needs_cs: assert property ($rose(par_data_oe) |-> !$past(par_cs_n, 3))
    else $error("data driven without chip select");
endmodule : hpirq_port_checker

bind hpirq_port hpirq_port_checker chk_i (
  .clk(clk), .rst_n(rst_n), .serial_parallel_select_pin(serial_parallel_select_pin),
  .bus_muxing_select_pin(bus_muxing_select_pin), .host_style_select_pin(host_style_select_pin),
  .serial_clk(serial_clk), .serial_cs_n(serial_cs_n), .serial_in_line(serial_in_line),
  .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe), .par_cs_n(par_cs_n),
  .par_strobe_n(par_strobe_n), .par_dir(par_dir), .par_addr_strobe(par_addr_strobe),
  .par_addr(par_addr), .par_data_in(par_data_in), .par_data_out(par_data_out),
  .par_data_oe(par_data_oe), .par_ack_n(par_ack_n), .par_rdy(par_rdy),
  .status_in(status_in), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

// File: bench/hpirq_host_model.sv
`timescale 1ns/100ps

// ============================================================
// Host processor model
module hpirq_host_model (
  // Clock.
  input wire logic clk,
  // Serial port.
  output logic serial_clk,
  output logic serial_cs_n,
  output logic serial_in_line,
  input wire logic serial_out_line,
  // Parallel port.
  output logic par_cs_n,
  output logic par_strobe_n,
  output logic par_dir,
  output logic par_addr_strobe,
  output logic [4:0] par_addr,
  output logic [7:0] par_data_in,
  input wire logic [7:0] par_data_out,
  input wire logic par_ack_n,
  input wire logic par_rdy
);
  // Idle levels; the shift clock stands low outside frames.
  initial begin
    serial_clk = 1'b0;
    serial_cs_n = 1'b1;
    serial_in_line = 1'b0;
    par_cs_n = 1'b1;
    par_strobe_n = 1'b1;
    par_dir = 1'b1;
    par_addr_strobe = 1'b0;
    par_addr = 5'h00;
    par_data_in = 8'h00;
  end

  // One sixteen-bit frame, command byte then data byte, first bit first.
  task ser_frame(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] q);
    @(posedge clk);
    serial_cs_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      serial_in_line <= (i < 8) ? cmd[i] : wd[i-8];
      repeat (8) @(posedge clk);
      if (i >= 8) q[i-8] = serial_out_line;
      serial_clk <= 1'b1;
      repeat (8) @(posedge clk);
      serial_clk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    serial_cs_n <= 1'b1;
    serial_in_line <= ~serial_in_line;
    repeat (10) @(posedge clk);
  endtask : ser_frame

  // One parallel access in any of the four bus modes.
  task par_access(input logic mux, input logic rw, input logic rd, input logic [4:0] a,
                  input logic [7:0] wd, output logic [7:0] q);
    int n;
    @(posedge clk);
    par_cs_n <= 1'b0;
    par_addr <= a;
    if (mux) begin
      par_addr_strobe <= rw;
      par_data_in <= {3'h0, a};
      repeat (6) @(posedge clk);
      par_addr_strobe <= !rw;
    end
    @(posedge clk);
    par_data_in <= rd ? ~par_data_in : wd;
    if (!rw) par_dir <= rd;
    if (rw && rd) par_dir <= 1'b0;
    else par_strobe_n <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((rw ? !par_rdy : par_ack_n) && n < 30);
    q = par_data_out;
    par_strobe_n <= 1'b1;
    par_dir <= 1'b1;
    par_cs_n <= 1'b1;
    par_data_in <= ~par_data_in;
    repeat (10) @(posedge clk);
  endtask : par_access
endmodule : hpirq_host_model

// File: bench/test_host_port_with_irq_logic.sv
`timescale 1ns/100ps
`include "hpirq_cfg.svh"

// ============================================================
// Testbench
module test_host_port_with_irq_logic;
  import hpirq_pkg::*;
  localparam logic [4:0] MASK_A [4] = '{`HPIRQ_A_CA_MASK, `HPIRQ_A_DS_MASK,
                                        `HPIRQ_A_AS_MASK, `HPIRQ_A_LC_MASK};
  localparam logic [4:0] STAT_A [4] = '{`HPIRQ_A_CA_STAT, `HPIRQ_A_DS_STAT,
                                        `HPIRQ_A_AS_STAT, `HPIRQ_A_LC_STAT};
  localparam logic [4:0] FLAG_A [4] = '{`HPIRQ_A_CA_FLAG, `HPIRQ_A_DS_FLAG,
                                        `HPIRQ_A_AS_FLAG, `HPIRQ_A_LC_FLAG};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel_par = 1'b0;
  logic sel_mux = 1'b0;
  logic sel_rw = 1'b0;
  hpirq_grp_arr_t st = '0;
  logic s_clk, s_cs_n, s_in, s_out, s_oe, p_cs_n, p_stb_n, p_dir, p_as, p_oe, p_ack_n, p_rdy;
  logic irq_out, irq_oe;
  logic [4:0] p_addr;
  logic [7:0] p_din, p_dout;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  hpirq_host_model host (.clk(clk), .serial_clk(s_clk), .serial_cs_n(s_cs_n), .par_cs_n(p_cs_n),
    .serial_in_line(s_in), .serial_out_line(s_out ^ ~s_oe), .par_strobe_n(p_stb_n),
    .par_dir(p_dir), .par_addr_strobe(p_as), .par_addr(p_addr), .par_data_in(p_din),
    .par_data_out(p_dout ^ {8{~p_oe}}), .par_ack_n(p_ack_n), .par_rdy(p_rdy));

  hpirq_port uut (.clk(clk), .rst_n(rst_n), .serial_parallel_select_pin(sel_par),
    .bus_muxing_select_pin(sel_mux), .host_style_select_pin(sel_rw), .serial_clk(s_clk),
    .serial_cs_n(s_cs_n), .serial_in_line(s_in), .serial_out_line(s_out), .serial_out_oe(s_oe),
    .par_cs_n(p_cs_n), .par_strobe_n(p_stb_n), .par_dir(p_dir), .par_addr_strobe(p_as),
    .par_addr(p_addr), .par_data_in(p_din), .par_data_out(p_dout), .par_data_oe(p_oe),
    .par_ack_n(p_ack_n), .par_rdy(p_rdy), .status_in(hpirq_group_t'(st)),
    .irq_n_out(irq_out), .irq_n_oe(irq_oe));

  // Compares one value and counts it.
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then stops.
  task end_of_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task ser_rd(input logic [4:0] a, output logic [7:0] q);
    host.ser_frame({2'b00, a, 1'b1}, 8'h00, q);
  endtask : ser_rd

  task par_io(input logic rd, input logic [4:0] a, input logic [7:0] wd, output logic [7:0] q);
    host.par_access(sel_mux, sel_rw, rd, a, wd, q);
  endtask : par_io

  // Waits a bounded time for the interrupt request.
  task wait_irq();
    int n;
    n = 0;
    while (irq_oe !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_irq

  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      end_of_test();
    end
  end

  // Main sequence.
  initial begin
    logic [7:0] q;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    for (int g = 0; g < 4; g++) begin
      ser_rd(MASK_A[g], q);
      check(q, 8'h00);
    end
    host.ser_frame({2'b11, MASK_A[0], 1'b0}, 8'ha5, q);
    ser_rd(MASK_A[0], q);
    check(q, 8'ha5);
    host.ser_frame({2'b00, 5'h1f, 1'b0}, 8'h5a, q);
    ser_rd(5'h1f, q);
    check(q, 8'h00);
    st[0] <= 8'h02;
    repeat (10) @(posedge clk);
    check({7'h0, irq_oe}, 8'h00);
    st[0] <= 8'h03;
    wait_irq();
    check({7'h0, irq_oe}, 8'h01);
    ser_rd(FLAG_A[0], q);
    check(q, 8'h01);
    ser_rd(STAT_A[0], q);
    check(q, 8'h03);
    ser_rd(FLAG_A[0], q);
    check(q, 8'h00);
    st[0] <= 8'h00;
    wait_irq();
    ser_rd(STAT_A[0], q);
    check(q, 8'h00);
    check({7'h0, irq_oe}, 8'h00);
    // Each group through one of the four parallel bus modes.
    for (int g = 0; g < 4; g++) begin
      @(posedge clk);
      sel_par <= 1'b1;
      sel_mux <= g[1];
      sel_rw <= g[0];
      repeat (8) @(posedge clk);
      par_io(1'b0, MASK_A[g], 8'h81, q);
      par_io(1'b1, MASK_A[g], 8'h00, q);
      check(q, 8'h81);
      st[g] <= 8'h83;
      wait_irq();
      par_io(1'b1, FLAG_A[g], 8'h00, q);
      check(q, 8'h81);
      par_io(1'b1, STAT_A[g], 8'h00, q);
      check(q, 8'h83);
      par_io(1'b1, FLAG_A[g], 8'h00, q);
      check(q, 8'h00);
      st[g] <= 8'h00;
      wait_irq();
      par_io(1'b1, FLAG_A[g], 8'h00, q);
      check(q, 8'h81);
      par_io(1'b1, STAT_A[g], 8'h00, q);
      check({7'h0, irq_oe}, 8'h00);
      par_io(1'b1, 5'h1f, 8'h00, q);
      check(q, 8'h00);
    end
    host.ser_frame({2'b00, MASK_A[3], 1'b0}, 8'hff, q);
    par_io(1'b1, MASK_A[3], 8'h00, q);
    check(q, 8'h81);
    end_of_test();
  end
endmodule : test_host_port_with_irq_logic
